// >>> verilog/usl_pkg.sv
package usl_pkg;
	localparam int          NUM_CH       = 4;
	// ---------------------------------------------------------------
	// Register addresses on A2..A0
	// ---------------------------------------------------------------
	localparam logic [2:0]  ADR_DATA     = 3'h0;
	localparam logic [2:0]  ADR_IER      = 3'h1;
	localparam logic [2:0]  ADR_ISR      = 3'h2;
	localparam logic [2:0]  ADR_LCR      = 3'h3;
	localparam logic [2:0]  ADR_MCR      = 3'h4;
	localparam logic [2:0]  ADR_LSR      = 3'h5;
	localparam logic [2:0]  ADR_MSR      = 3'h6;
	localparam logic [2:0]  ADR_SPR      = 3'h7;
	// ---------------------------------------------------------------
	// Field positions and key values
	// ---------------------------------------------------------------
	localparam logic [7:0]  LCR_ENH_KEY  = 8'hBF;
	localparam int          LCR_DIV_BIT  = 7;
	localparam int          IER_SLEEP    = 4;
	localparam int          MCR_LOOP     = 4;
	localparam int          EFR_ENH      = 4;
	localparam int          FEATURE_CONTROL_FIFO_LEVEL_VIEW    = 6;
	localparam int          ISR_NONE_BIT = 0;
	localparam int          FCR_FIFO_EN  = 0;
	localparam int          ENHANCED_MODE_SELECT_TXCNT   = 0;
	localparam logic [3:0]  IER_LOW_MASK = 4'hF;
	localparam logic [4:0]  MCR_LOW_MASK = 5'h1F;
	localparam logic [7:0]  ISR_NO_INT   = 8'h01;
	localparam logic [7:0]  ISR_RX_DATA  = 8'h04;
	localparam logic [7:0]  ISR_TX_EMPTY = 8'h02;
	localparam logic [7:0]  ISR_MODEM    = 8'h00;
	// ---------------------------------------------------------------
	// Serial framing and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0]  TX_FRAME     = 4'hA;
	localparam logic [3:0]  RX_FRAME     = 4'h9;
	localparam logic [7:0]  REG_RESET    = 8'h00;
	localparam logic [15:0] BAUD_RESET   = 16'h0000;

	typedef enum logic [4:0] {
		RG_NONE, RG_DATA, RG_IER, RG_ISR_FCR, RG_LCR, RG_MCR, RG_LSR, RG_MSR,
		RG_SPR, RG_FIFO_LEVEL_VIEW_ENHANCED_MODE_SELECT, RG_DLL, RG_DLM, RG_TRG_FC, RG_FEATURE_CONTROL, RG_EFR,
		RG_XON1, RG_XON2, RG_XOFF1, RG_XOFF2
	} usl_reg_t;

	typedef enum logic {PWR_AWAKE = 1'b0, PWR_ASLEEP = 1'b1} usl_pwr_t;

	typedef struct packed {
		logic [3:0] cs_n;
		logic [2:0] a;
		logic [7:0] d;
		logic       ior_n;
		logic       iow_n;
		logic       fifo_status_select_n_n;
		logic [3:0] rx;
		logic [3:0] cts_n;
		logic [3:0] dsr_n;
		logic [3:0] cd_n;
		logic [3:0] ri_n;
	} usl_pins_t;

	typedef struct packed {
		logic [7:0]  line_control, interrupt_enable, modem_control, dll, divisor_high, scratch, feature_control, enhanced_function;
		logic [7:0]  xon1, xon2, xoff1, xoff2, fifo_trigger_levels, enhanced_mode_select, fifo_control;
		logic [7:0]  tx_holding, rx_holding, rx_shift;
		logic        thr_full, rx_ready, overrun;
		logic [9:0]  tx_shift;
		logic [3:0]  tx_cnt, rx_cnt;
		logic        tx_busy, rx_busy, tx_line;
		logic [3:0]  delta, mdm_prev;
		logic [15:0] baud_cnt;
		logic        tx_pin, rts_n, dtr_n;
	} usl_chan_t;

	typedef struct packed {
		usl_pins_t                meta, sync;
		logic                     rd_prev, wr_prev;
		usl_pwr_t                 pwr;
		logic                     osc;
		logic [7:0]               dout;
		logic                     doe;
		usl_chan_t [NUM_CH-1:0]   ch;
	} usl_state_t;
endpackage : usl_pkg

// >>> verilog/usl_uart_core.sv
module usl_uart_core #(
	parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
	parameter logic [7:0] IDENT    = 8'h5A  // Arbitrary value
) (
	input  wire logic       MCLK,
	input  wire logic       RSTN,
	input  wire logic [3:0] CS_N,
	input  wire logic [2:0] A,
	input  wire logic [7:0] D_IN,
	output logic      [7:0] D_OUT,
	output logic            D_OE,
	input  wire logic       IOR_N,
	input  wire logic       IOW_N,
	input  wire logic       FIFO_STATUS_SELECT_N,
	input  wire logic [3:0] RX,
	input  wire logic [3:0] CTS_N,
	input  wire logic [3:0] DSR_N,
	input  wire logic [3:0] CD_N,
	input  wire logic [3:0] RI_N,
	output logic      [3:0] TX,
	output logic      [3:0] RTS_N,
	output logic      [3:0] DTR_N,
	output logic            OSCILLATOR_OUTPUT
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [1:0] cs_index(input logic [3:0] cs_n);
		logic [1:0] idx;
		idx = 2'd0;
		for (int k = usl_pkg::NUM_CH - 1; k >= 0; k--) begin
			if (!cs_n[k]) begin
				idx = 2'(k);
			end
		end
		return idx;
	endfunction : cs_index

	function automatic usl_pkg::usl_reg_t decode(input logic [2:0] adr,
		input logic [7:0] line_control, input logic fifo_level_view_sel);
		usl_pkg::usl_reg_t r;
		r = usl_pkg::RG_NONE;
		if (adr == usl_pkg::ADR_LCR) begin
			r = usl_pkg::RG_LCR;
		end else if (line_control == usl_pkg::LCR_ENH_KEY) begin
			unique case (adr)
				usl_pkg::ADR_DATA: r = usl_pkg::RG_TRG_FC;
				usl_pkg::ADR_IER:  r = usl_pkg::RG_FEATURE_CONTROL;
				usl_pkg::ADR_ISR:  r = usl_pkg::RG_EFR;
				usl_pkg::ADR_MCR:  r = usl_pkg::RG_XON1;
				usl_pkg::ADR_LSR:  r = usl_pkg::RG_XON2;
				usl_pkg::ADR_MSR:  r = usl_pkg::RG_XOFF1;
				usl_pkg::ADR_SPR:  r = usl_pkg::RG_XOFF2;
				default:           r = usl_pkg::RG_NONE;
			endcase
		end else if (line_control[usl_pkg::LCR_DIV_BIT]) begin
			if (adr == usl_pkg::ADR_DATA) begin
				r = usl_pkg::RG_DLL;
			end else if (adr == usl_pkg::ADR_IER) begin
				r = usl_pkg::RG_DLM;
			end
		end else begin
			unique case (adr)
				usl_pkg::ADR_DATA: r = usl_pkg::RG_DATA;
				usl_pkg::ADR_IER:  r = usl_pkg::RG_IER;
				usl_pkg::ADR_ISR:  r = usl_pkg::RG_ISR_FCR;
				usl_pkg::ADR_MCR:  r = usl_pkg::RG_MCR;
				usl_pkg::ADR_LSR:  r = usl_pkg::RG_LSR;
				usl_pkg::ADR_MSR:  r = usl_pkg::RG_MSR;
				usl_pkg::ADR_SPR:  r = fifo_level_view_sel ? usl_pkg::RG_FIFO_LEVEL_VIEW_ENHANCED_MODE_SELECT
				                                : usl_pkg::RG_SPR;
				default:           r = usl_pkg::RG_NONE;
			endcase
		end
		return r;
	endfunction : decode

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	usl_pkg::usl_state_t           s;
	usl_pkg::usl_state_t           next_s;
	usl_pkg::usl_pins_t            pins_now;
	usl_pkg::usl_reg_t             rsel;
	logic                          rd_act;
	logic                          wr_act;
	logic                          rd_start;
	logic                          wr_start;
	logic [1:0]                    chn;
	logic [7:0]                    rdv;
	logic                          wr_thr;
	logic                          sleep_ok;
	logic                          wake;
	logic [usl_pkg::NUM_CH-1:0]    tick;
	logic [usl_pkg::NUM_CH-1:0]    loop;
	logic [usl_pkg::NUM_CH-1:0]    rx_in;
	logic [3:0]                    mdm [usl_pkg::NUM_CH];
	logic [7:0]                    interrupt_status [usl_pkg::NUM_CH];
	logic [15:0]                   div_m1;
	logic [7:0]                    fifo_ready_status;
	// Synchronisers restart at pin idle levels, so no false strobe or edge follows reset
	localparam usl_pkg::usl_pins_t PINS_IDLE = '{cs_n: 4'hF, a: 3'h0, d: 8'h00, ior_n: 1'b1,
		iow_n: 1'b1, fifo_status_select_n_n: 1'b1, rx: 4'hF, cts_n: 4'hF, dsr_n: 4'hF, cd_n: 4'hF, ri_n: 4'hF};

	always_comb begin
		pins_now = '{cs_n: CS_N, a: A, d: D_IN, ior_n: IOR_N, iow_n: IOW_N,
		             fifo_status_select_n_n: FIFO_STATUS_SELECT_N, rx: RX, cts_n: CTS_N,
		             dsr_n: DSR_N, cd_n: CD_N, ri_n: RI_N};
	end

	always_comb begin
		next_s   = s;
		tick     = '0;
		loop     = '0;
		rx_in    = '0;
		div_m1   = '0;
		fifo_ready_status    = '0;
		rdv      = '0;
		wr_thr   = 1'b0;
		sleep_ok = 1'b1;
		wake     = 1'b0;
		for (int i = 0; i < usl_pkg::NUM_CH; i++) begin
			mdm[i] = '0;
			interrupt_status[i] = usl_pkg::ISR_NO_INT;
		end
		// Pins pass two flops; only the second stage is looked at
		next_s.meta = pins_now;
		next_s.sync = s.meta;

		// -----------------------------------------------------------
		// Per-channel derived values
		// -----------------------------------------------------------
		for (int i = 0; i < usl_pkg::NUM_CH; i++) begin
			loop[i] = s.ch[i].modem_control[usl_pkg::MCR_LOOP];
			// Status order: CD, RI, DSR, CTS, active high
			if (loop[i]) begin
				mdm[i] = {s.ch[i].modem_control[3], s.ch[i].modem_control[2],
				          s.ch[i].modem_control[0], s.ch[i].modem_control[1]};
			end else begin
				mdm[i] = ~{s.sync.cd_n[i], s.sync.ri_n[i],
				           s.sync.dsr_n[i], s.sync.cts_n[i]};
			end
			rx_in[i] = loop[i] ? s.ch[i].tx_line : s.sync.rx[i];
			if (mdm[i] != s.ch[i].mdm_prev || !s.sync.rx[i]) begin
				wake = 1'b1;
			end
			if (s.ch[i].interrupt_enable[0] && s.ch[i].rx_ready) begin
				interrupt_status[i] = usl_pkg::ISR_RX_DATA;
			end else if (s.ch[i].interrupt_enable[1] && !s.ch[i].thr_full) begin
				interrupt_status[i] = usl_pkg::ISR_TX_EMPTY;
			end else if (s.ch[i].interrupt_enable[3] && (|s.ch[i].delta)) begin
				interrupt_status[i] = usl_pkg::ISR_MODEM;
			end
			interrupt_status[i][7:6] = {2{s.ch[i].fifo_control[usl_pkg::FCR_FIFO_EN]}};
			fifo_ready_status[i]     = !s.ch[i].thr_full;
			fifo_ready_status[i + 4] = s.ch[i].rx_ready;
		end

		// -----------------------------------------------------------
		// Host bus: channel select and address decode
		// -----------------------------------------------------------
		rd_act = !s.sync.ior_n && !(&s.sync.cs_n);
		wr_act = !s.sync.iow_n && !(&s.sync.cs_n);
		rd_start = rd_act && !s.rd_prev;
		wr_start = wr_act && !s.wr_prev;
		next_s.rd_prev = rd_act;
		next_s.wr_prev = wr_act;
		chn  = cs_index(s.sync.cs_n);
		rsel = decode(s.sync.a, s.ch[chn].line_control,
		              s.ch[chn].feature_control[usl_pkg::FEATURE_CONTROL_FIFO_LEVEL_VIEW]);

		unique case (rsel)
			usl_pkg::RG_DATA:      rdv = s.ch[chn].rx_holding;
			usl_pkg::RG_IER:       rdv = s.ch[chn].interrupt_enable;
			usl_pkg::RG_ISR_FCR:   rdv = interrupt_status[chn];
			usl_pkg::RG_LCR:       rdv = s.ch[chn].line_control;
			usl_pkg::RG_MCR:       rdv = s.ch[chn].modem_control;
			usl_pkg::RG_LSR:       rdv = {1'b0,
			                              !s.ch[chn].thr_full && !s.ch[chn].tx_busy,
			                              !s.ch[chn].thr_full, 3'b000,
			                              s.ch[chn].overrun, s.ch[chn].rx_ready};
			usl_pkg::RG_MSR:       rdv = {mdm[chn], s.ch[chn].delta};
			usl_pkg::RG_SPR:       rdv = s.ch[chn].scratch;
			usl_pkg::RG_FIFO_LEVEL_VIEW_ENHANCED_MODE_SELECT,
			usl_pkg::RG_TRG_FC:    rdv = {7'h00, s.ch[chn].enhanced_mode_select[usl_pkg::ENHANCED_MODE_SELECT_TXCNT]
			                              ? s.ch[chn].thr_full : s.ch[chn].rx_ready};
			usl_pkg::RG_DLL:       rdv = ({s.ch[chn].divisor_high, s.ch[chn].dll} == '0)
			                             ? REVISION : s.ch[chn].dll;
			usl_pkg::RG_DLM:       rdv = ({s.ch[chn].divisor_high, s.ch[chn].dll} == '0)
			                             ? IDENT : s.ch[chn].divisor_high;
			usl_pkg::RG_FEATURE_CONTROL:      rdv = s.ch[chn].feature_control;
			usl_pkg::RG_EFR:       rdv = s.ch[chn].enhanced_function;
			usl_pkg::RG_XON1:      rdv = s.ch[chn].xon1;
			usl_pkg::RG_XON2:      rdv = s.ch[chn].xon2;
			usl_pkg::RG_XOFF1:     rdv = s.ch[chn].xoff1;
			usl_pkg::RG_XOFF2:     rdv = s.ch[chn].xoff2;
			usl_pkg::RG_NONE:      rdv = '0;
		endcase
		if (!s.sync.fifo_status_select_n_n) begin
			rdv = fifo_ready_status;
		end

		// Read data frozen at strobe start so side effects stay invisible
		next_s.doe = rd_act;
		if (rd_start) begin
			next_s.dout = rdv;
			if (s.sync.fifo_status_select_n_n && rsel == usl_pkg::RG_DATA) begin
				next_s.ch[chn].rx_ready = 1'b0;
			end
			if (s.sync.fifo_status_select_n_n && rsel == usl_pkg::RG_MSR) begin
				next_s.ch[chn].delta = '0;
			end
			if (s.sync.fifo_status_select_n_n && rsel == usl_pkg::RG_LSR) begin
				next_s.ch[chn].overrun = 1'b0;
			end
		end

		if (wr_start) begin
			unique case (rsel)
				usl_pkg::RG_DATA: begin
					next_s.ch[chn].tx_holding      = s.sync.d;
					next_s.ch[chn].thr_full = 1'b1;
					wr_thr = 1'b1;
				end
				usl_pkg::RG_IER: begin
					next_s.ch[chn].interrupt_enable[3:0] = s.sync.d[3:0] & usl_pkg::IER_LOW_MASK;
					if (s.ch[chn].enhanced_function[usl_pkg::EFR_ENH]) begin
						next_s.ch[chn].interrupt_enable[7:4] = s.sync.d[7:4];
					end
				end
				usl_pkg::RG_MCR: begin
					next_s.ch[chn].modem_control[4:0] = s.sync.d[4:0] & usl_pkg::MCR_LOW_MASK;
					if (s.ch[chn].enhanced_function[usl_pkg::EFR_ENH]) begin
						next_s.ch[chn].modem_control[7:5] = s.sync.d[7:5];
					end
				end
				usl_pkg::RG_ISR_FCR:   next_s.ch[chn].fifo_control   = s.sync.d;
				usl_pkg::RG_LCR:       next_s.ch[chn].line_control   = s.sync.d;
				usl_pkg::RG_SPR:       next_s.ch[chn].scratch   = s.sync.d;
				usl_pkg::RG_FIFO_LEVEL_VIEW_ENHANCED_MODE_SELECT: next_s.ch[chn].enhanced_mode_select  = s.sync.d;
				usl_pkg::RG_DLL:       next_s.ch[chn].dll   = s.sync.d;
				usl_pkg::RG_DLM:       next_s.ch[chn].divisor_high   = s.sync.d;
				usl_pkg::RG_TRG_FC:    next_s.ch[chn].fifo_trigger_levels   = s.sync.d;
				usl_pkg::RG_FEATURE_CONTROL:      next_s.ch[chn].feature_control  = s.sync.d;
				usl_pkg::RG_EFR:       next_s.ch[chn].enhanced_function   = s.sync.d;
				usl_pkg::RG_XON1:      next_s.ch[chn].xon1  = s.sync.d;
				usl_pkg::RG_XON2:      next_s.ch[chn].xon2  = s.sync.d;
				usl_pkg::RG_XOFF1:     next_s.ch[chn].xoff1 = s.sync.d;
				usl_pkg::RG_XOFF2:     next_s.ch[chn].xoff2 = s.sync.d;
				usl_pkg::RG_LSR,
				usl_pkg::RG_MSR,
				usl_pkg::RG_NONE:      next_s.ch[chn].scratch   = s.ch[chn].scratch;
			endcase
		end

		if (wr_thr) begin
			wake = 1'b1;
		end
		// -----------------------------------------------------------
		// Serial engines, one bit per divisor period
		// -----------------------------------------------------------
		for (int i = 0; i < usl_pkg::NUM_CH; i++) begin
			div_m1 = ({s.ch[i].divisor_high, s.ch[i].dll} == '0) ? '0
			       : 16'({s.ch[i].divisor_high, s.ch[i].dll} - 16'h0001);
			// Stopped oscillator freezes bit timing; the wake cycle counts so a start bit survives
			if (s.pwr == usl_pkg::PWR_AWAKE || wake) begin
				tick[i] = (s.ch[i].baud_cnt >= div_m1);
				next_s.ch[i].baud_cnt = tick[i] ? '0
				                      : 16'(s.ch[i].baud_cnt + 16'h0001);
			end
			if (tick[i]) begin
				if (s.ch[i].tx_busy) begin
					next_s.ch[i].tx_line  = s.ch[i].tx_shift[0];
					next_s.ch[i].tx_shift = {1'b1, s.ch[i].tx_shift[9:1]};
					next_s.ch[i].tx_cnt   = 4'(s.ch[i].tx_cnt - 4'h1);
					next_s.ch[i].tx_busy  = (s.ch[i].tx_cnt != 4'h1);
				end else if (s.ch[i].thr_full) begin
					next_s.ch[i].tx_shift = {1'b1, s.ch[i].tx_holding, 1'b0};
					next_s.ch[i].tx_cnt   = usl_pkg::TX_FRAME;
					next_s.ch[i].tx_busy  = 1'b1;
					next_s.ch[i].thr_full = 1'b0;
				end
				if (s.ch[i].rx_busy) begin
					next_s.ch[i].rx_cnt = 4'(s.ch[i].rx_cnt - 4'h1);
					if (s.ch[i].rx_cnt == 4'h1) begin
						next_s.ch[i].rx_busy = 1'b0;
						next_s.ch[i].rx_holding     = s.ch[i].rx_shift;
						next_s.ch[i].overrun = s.ch[i].overrun || s.ch[i].rx_ready;
						next_s.ch[i].rx_ready = 1'b1;
					end else begin
						next_s.ch[i].rx_shift = {rx_in[i], s.ch[i].rx_shift[7:1]};
					end
				end else if (!rx_in[i]) begin
					next_s.ch[i].rx_busy = 1'b1;
					next_s.ch[i].rx_cnt  = usl_pkg::RX_FRAME;
				end
			end
			// Host write lands after the loader so new data is never lost
			if (wr_thr && chn == 2'(i)) begin
				next_s.ch[i].thr_full = 1'b1;
			end
			// Deltas: a change in the same cycle as the read wins
			next_s.ch[i].mdm_prev = mdm[i];
			for (int b = 0; b < 4; b++) begin
				if (mdm[i][b] != s.ch[i].mdm_prev[b]) begin
					next_s.ch[i].delta[b] = 1'b1;
				end
			end
			next_s.ch[i].tx_pin = loop[i] ? 1'b1 : s.ch[i].tx_line;
			next_s.ch[i].rts_n  = loop[i] ? 1'b1 : !s.ch[i].modem_control[1];
			next_s.ch[i].dtr_n  = loop[i] ? 1'b1 : !s.ch[i].modem_control[0];

			// -------------------------------------------------------
			// Sleep entry terms
			// -------------------------------------------------------
			if (!interrupt_status[i][usl_pkg::ISR_NONE_BIT]) begin
				sleep_ok = 1'b0;
			end
			if (!s.ch[i].interrupt_enable[usl_pkg::IER_SLEEP]) begin
				sleep_ok = 1'b0;
			end
			if (|s.ch[i].delta) begin
				sleep_ok = 1'b0;
			end
			if (!s.sync.rx[i] || s.ch[i].rx_busy) begin
				sleep_ok = 1'b0;
			end
			if (s.ch[i].thr_full || s.ch[i].tx_busy) begin
				sleep_ok = 1'b0;
			end
		end
		// Sleep is re-entered whenever the terms hold again
		next_s.pwr = (sleep_ok && !wake) ? usl_pkg::PWR_ASLEEP
		                                 : usl_pkg::PWR_AWAKE;
		next_s.osc = (s.pwr == usl_pkg::PWR_ASLEEP) ? 1'b0 : !s.osc;
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge MCLK) begin
		if (!RSTN) begin
			s      <= '0;
			s.meta <= PINS_IDLE;
			s.sync <= PINS_IDLE;
			for (int i = 0; i < usl_pkg::NUM_CH; i++) begin
				s.ch[i].tx_line  <= 1'b1;
				s.ch[i].tx_pin   <= 1'b1;
				s.ch[i].rts_n    <= 1'b1;
				s.ch[i].dtr_n    <= 1'b1;
				s.ch[i].baud_cnt <= usl_pkg::BAUD_RESET;
				s.ch[i].line_control      <= usl_pkg::REG_RESET;
			end
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		D_OUT             = s.dout;
		D_OE              = s.doe;
		OSCILLATOR_OUTPUT = s.osc;
		for (int i = 0; i < usl_pkg::NUM_CH; i++) begin
			TX[i]    = s.ch[i].tx_pin;
			RTS_N[i] = s.ch[i].rts_n;
			DTR_N[i] = s.ch[i].dtr_n;
		end
	end
endmodule : usl_uart_core

// >>> testbench/usl_uart_core_properties.sv
module usl_chk (
	input wire logic       MCLK,
	input wire logic       RSTN,
	input wire logic [3:0] CS_N,
	input wire logic       IOR_N,
	input wire logic [3:0] RX,
	input wire logic [3:0] CTS_N,
	input wire logic [3:0] DSR_N,
	input wire logic       D_OE,
	input wire logic [3:0] TX,
	input wire logic [3:0] RTS_N,
	input wire logic [3:0] DTR_N,
	input wire logic       OSCILLATOR_OUTPUT
);
	logic osc_q;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RSTN);
	always_ff @(posedge MCLK) begin
		osc_q <= OSCILLATOR_OUTPUT;
	end
	// ---------------------------------------------------------------
	// Sleep and wake
	// ---------------------------------------------------------------
	// Two equal samples in a row can only be a stopped oscillator
	a_osc_stops_low: assert property (
		$past(RSTN) && OSCILLATOR_OUTPUT == osc_q |-> !OSCILLATOR_OUTPUT)
		else $error("oscillator stalled high");
	a_wake_on_start: assert property (
		!OSCILLATOR_OUTPUT && !osc_q && |($past(RX) & ~RX) |-> ##[1:8] OSCILLATOR_OUTPUT)
		else $error("no wake after start bit");
	a_wake_on_modem: assert property (
		!OSCILLATOR_OUTPUT && !osc_q && (CTS_N != $past(CTS_N) || DSR_N != $past(DSR_N))
		|-> ##[1:8] OSCILLATOR_OUTPUT) else $error("no wake after modem change");
	a_rx_low_awake: assert property (
		(RX != 4'hF) [*8] |-> $changed(OSCILLATOR_OUTPUT))
		else $error("asleep with receive input low");
	// ---------------------------------------------------------------
	// Host bus and serial line levels after reset
	// ---------------------------------------------------------------
	a_read_drives: assert property (
		$fell(IOR_N) && CS_N != 4'hF |-> ##[3:5] D_OE) else $error("read not driven");
	a_read_release: assert property (
		$rose(IOR_N) |-> ##[3:5] !D_OE) else $error("bus not released");
	a_bus_quiet: assert property (
		IOR_N [*8] |-> !D_OE) else $error("bus driven without read");
	a_reset_lines: assert property (
		!$past(RSTN) |-> TX == 4'hF && RTS_N == 4'hF && DTR_N == 4'hF)
		else $error("serial lines not idle after reset");
endmodule : usl_chk

bind usl_uart_core usl_chk chk_u (.MCLK, .RSTN, .CS_N, .IOR_N, .RX, .CTS_N, .DSR_N, .D_OE,
	.TX, .RTS_N, .DTR_N, .OSCILLATOR_OUTPUT);

// >>> testbench/usl_far_end.sv
module usl_far_end (
	input  wire logic       MCLK,
	input  wire logic [3:0] TX,
	output logic      [3:0] RX,
	output logic      [3:0] CTS_N,
	output logic      [3:0] DSR_N,
	output logic      [3:0] CD_N,
	output logic      [3:0] RI_N
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		RX = 4'hF;
		CTS_N = 4'hF;
		DSR_N = 4'hF;
		CD_N = 4'hF;
		RI_N = 4'hF;
	end
	// One bit per cycle: the device divisor is left at its reset value
	task automatic send(input int ch, input logic [7:0] v);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge MCLK);
			RX[ch] = f[i];
		end
		@(negedge MCLK);
	endtask : send
	task automatic hold_rx(input int ch, input logic v);
		@(negedge MCLK);
		RX[ch] = v;
	endtask : hold_rx
	task automatic flip(input int ch, input bit dsr);
		@(negedge MCLK);
		if (dsr) begin
			DSR_N[ch] = ~DSR_N[ch];
		end else begin
			CTS_N[ch] = ~CTS_N[ch];
		end
	endtask : flip
	task automatic grab(input int ch, output logic [7:0] v);
		int n;
		n = 0;
		while (TX[ch] !== 1'b0 && n < 300) begin
			@(negedge MCLK);
			n++;
		end
		for (int i = 0; i < 8; i++) begin
			@(negedge MCLK);
			v[i] = TX[ch];
		end
	endtask : grab
endmodule : usl_far_end

// >>> testbench/uart_sleep_loopback_regmap_tb.sv
module uart_sleep_loopback_regmap_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] REV_CODE = 8'h3C; // Arbitrary value
	localparam logic [7:0] ID_CODE  = 8'hC3; // Arbitrary value
	logic       mclk  = 1'b0;
	logic       rstn  = 1'b0;
	logic [3:0] cs_n  = 4'hF;
	logic [2:0] a     = 3'h0;
	logic [7:0] d_in  = 8'h00;
	logic       ior_n = 1'b1;
	logic       iow_n = 1'b1;
	logic       fss_n = 1'b1;
	logic [7:0] d_out;
	logic       d_oe;
	logic [3:0] tx, rts_n, dtr_n, rx, cts_n, dsr_n, cd_n, ri_n;
	logic       osc;
	logic [7:0] b, g, q;
	int         bad_count    = 0;
	int         total_checks = 0;
	int         m_spr[4];
	always #5 mclk = ~mclk;
	usl_uart_core #(.REVISION(REV_CODE), .IDENT(ID_CODE)) dut_u (.MCLK(mclk), .RSTN(rstn),
		.CS_N(cs_n), .A(a), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .IOR_N(ior_n),
		.IOW_N(iow_n), .FIFO_STATUS_SELECT_N(fss_n), .RX(rx), .CTS_N(cts_n), .DSR_N(dsr_n),
		.CD_N(cd_n), .RI_N(ri_n), .TX(tx), .RTS_N(rts_n), .DTR_N(dtr_n),
		.OSCILLATOR_OUTPUT(osc));
	usl_far_end far_u (.MCLK(mclk), .TX(tx), .RX(rx), .CTS_N(cts_n), .DSR_N(dsr_n),
		.CD_N(cd_n), .RI_N(ri_n));
	// ---------------------------------------------------------------
	// Host bus and comparison
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Address and select settle two cycles ahead of the strobe for the synchronisers
	task automatic bus(input int ch, input logic [2:0] ad, input logic [7:0] dv,
			input bit rd, output logic [7:0] r);
		@(negedge mclk);
		cs_n = ~(4'h1 << ch);
		a = ad;
		d_in = dv;
		repeat (2) @(negedge mclk);
		ior_n = ~rd;
		iow_n = rd;
		repeat (6) @(negedge mclk);
		r = d_out;
		ior_n = 1'b1;
		iow_n = 1'b1;
		repeat (6) @(negedge mclk);
		cs_n = 4'hF;
	endtask : bus
	task automatic wr(input int ch, input logic [2:0] ad, input logic [7:0] dv);
		logic [7:0] x;
		bus(ch, ad, dv, 1'b0, x);
	endtask : wr
	task automatic rc(input int ch, input logic [2:0] ad, input logic [7:0] e, input string nm);
		bus(ch, ad, 8'h00, 1'b1, q);
		chk(nm, e, q);
	endtask : rc
	// Trailing run of a still oscillator decides asleep or awake
	task automatic nap(input logic e, input string nm);
		int z;
		z = 0;
		repeat (60) begin
			@(negedge mclk);
			z = (osc === 1'b0) ? z + 1 : 0;
		end
		chk(nm, {7'h00, e}, {7'h00, z >= 4});
	endtask : nap
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#100us;
		bad_count++;
		give_verdict();
	end
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	initial begin
		void'($urandom(62));
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		repeat (3) @(negedge mclk);
		for (int c = 0; c < 4; c++) begin
			m_spr[c] = $urandom % 256;
			wr(c, 3'h7, m_spr[c][7:0]);
		end
		for (int c = 0; c < 4; c++) rc(c, 3'h7, m_spr[c][7:0], "scratch");
		rc(1, 3'h2, 8'h01, "int status");
		wr(0, 3'h3, 8'h80);
		rc(0, 3'h3, 8'h80, "line control");
		rc(0, 3'h0, REV_CODE, "revision");
		rc(0, 3'h1, ID_CODE, "ident");
		b = $urandom | 8'h01;
		wr(0, 3'h0, b);
		rc(0, 3'h0, b, "divisor low");
		rc(0, 3'h1, 8'h00, "divisor high");
		wr(0, 3'h0, 8'h00);
		wr(0, 3'h3, usl_pkg::LCR_ENH_KEY);
		rc(0, 3'h3, usl_pkg::LCR_ENH_KEY, "line control key");
		wr(0, 3'h2, 8'h10);
		rc(0, 3'h2, 8'h10, "enhanced function");
		wr(0, 3'h1, 8'h40);
		rc(0, 3'h1, 8'h40, "feature control");
		for (int i = 4; i < 8; i++) begin
			b = $urandom;
			wr(0, i[2:0], b);
			rc(0, i[2:0], b, "flow character");
		end
		wr(0, 3'h3, 8'h00);
		wr(0, 3'h7, 8'h55);
		rc(0, 3'h7, 8'h00, "level view");
		wr(1, 3'h1, 8'h30);
		rc(1, 3'h1, 8'h00, "locked enables");
		wr(0, 3'h1, 8'h10);
		rc(0, 3'h1, 8'h10, "sleep enable");
		fss_n = 1'b0;
		rc(2, 3'h5, 8'h0F, "ready status");
		fss_n = 1'b1;
		wr(0, 3'h4, 8'h13);
		chk("loop lines", {5'h00, tx[0], rts_n[0], dtr_n[0]}, 8'h07);
		far_u.flip(0, 1'b0);
		rc(0, 3'h6, 8'h33, "loop modem");
		far_u.flip(0, 1'b0);
		rc(0, 3'h6, 8'h30, "loop modem clear");
		b = $urandom;
		wr(0, 3'h0, b);
		chk("loop mark", {7'h00, tx[0]}, 8'h01);
		q = 8'h00;
		for (int i = 0; i < 8 && q[0] !== 1'b1; i++) bus(0, 3'h5, 8'h00, 1'b1, q);
		rc(0, 3'h0, b, "loop data");
		wr(0, 3'h4, 8'h00);
		rc(0, 3'h6, 8'h03, "modem after loop");
		for (int c = 1; c < 4; c++) begin
			wr(c, 3'h3, usl_pkg::LCR_ENH_KEY);
			wr(c, 3'h2, 8'h10);
			wr(c, 3'h3, 8'h00);
			wr(c, 3'h1, 8'h10);
		end
		nap(1'b1, "asleep");
		b = $urandom;
		far_u.send(2, b);
		rc(2, 3'h0, b, "received byte");
		nap(1'b1, "asleep after receive");
		far_u.flip(1, 1'b1);
		nap(1'b0, "modem wake");
		rc(1, 3'h6, 8'h22, "modem status");
		nap(1'b1, "asleep after modem");
		b = $urandom;
		fork
			wr(3, 3'h0, b);
			far_u.grab(3, g);
		join
		chk("sent byte", b, g);
		nap(1'b1, "asleep after send");
		wr(3, 3'h1, 8'h12);
		nap(1'b0, "pending blocks sleep");
		wr(3, 3'h1, 8'h10);
		nap(1'b1, "asleep again");
		far_u.hold_rx(1, 1'b0);
		nap(1'b0, "receive low");
		far_u.hold_rx(1, 1'b1);
		nap(1'b1, "asleep after break");
		wr(2, 3'h1, 8'h00);
		nap(1'b0, "sleep disabled");
		give_verdict();
	end
endmodule : uart_sleep_loopback_regmap_tb
